/* File: include/fan_regs_pkg.sv */
/*
  Constants, types and helpers for the fan duty ramp engine and the
  measurement register bank. Assumes one 100 MHz core clock and a byte-wide
  register port fed by the serial management bus front end.
*/
`default_nettype none
package fan_regs_pkg;
  localparam logic [7:0] ADDR_TEMP_FRACTION = 8'h06;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h09;
  localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h0a;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_LOCAL_UPPER = 8'h14;
  localparam logic [7:0] ADDR_LOCAL_LOWER = 8'h15;
  localparam logic [7:0] ADDR_LOCAL_THERMAL = 8'h16;
  localparam logic [7:0] ADDR_REMOTE_UPPER = 8'h18;
  localparam logic [7:0] ADDR_REMOTE_LOWER = 8'h19;
  localparam logic [7:0] ADDR_REMOTE_THERMAL = 8'h1a;
  localparam logic [7:0] ADDR_LOCAL_CRITICAL = 8'h1b;
  localparam logic [7:0] ADDR_PASSIVE = 8'h1c;
  localparam logic [7:0] ADDR_REMOTE_CRITICAL = 8'h1d;
  localparam logic [7:0] ADDR_DUTY_RAMP = 8'h23;

  localparam logic [7:0] RST_TEMP_HIGH = 8'h80;
  localparam logic [7:0] RST_LOCAL_UPPER = 8'h3c;
  localparam logic [7:0] RST_LOCAL_THERMAL = 8'h46;
  localparam logic [7:0] RST_REMOTE_UPPER = 8'h50;
  localparam logic [7:0] RST_REMOTE_THERMAL = 8'h64;
  localparam logic [7:0] RST_LOCAL_CRITICAL = 8'h50;
  localparam logic [7:0] RST_REMOTE_CRITICAL = 8'h69;
  localparam logic [7:0] RST_DUTY_RAMP = 8'h52;
  localparam logic [7:0] PASSIVE_MASK = 8'h3f;

  // duty ramp register fields
  localparam int RAMP_EN_BIT = 7;
  localparam int STEP_LSB = 5;
  localparam int RATE_LSB = 2;
  localparam int THRESH_LSB = 0;

  localparam logic [15:0] TACH_WINDOW = 16'h000a;
  localparam logic [2:0] RATE_FASTEST = 3'h7;

  // timing: rate code 111 is 8 updates per second
  localparam int CLK_KHZ = 100000;
  localparam int UPDATE_BASE_MS = 125;
  localparam int UPDATE_BASE_CYCLES = UPDATE_BASE_MS * CLK_KHZ;
  localparam int TACH_SLOW_MS = 1000;
  localparam int TACH_SLOW_CYCLES = TACH_SLOW_MS * CLK_KHZ;
  localparam int TACH_FAST_MS = 250;
  localparam int TACH_FAST_CYCLES = TACH_FAST_MS * CLK_KHZ;

  typedef enum logic [1:0] {MODE_SW_DUTY, MODE_AUTO_TEMP, MODE_SW_RPM} fan_mode_t;

  function automatic logic [15:0] abs_diff16(input logic [15:0] a, input logic [15:0] b);
    abs_diff16 = (a > b) ? a - b : b - a;
  endfunction : abs_diff16

  function automatic logic [7:0] step_size(input logic [1:0] code);
    step_size = 8'h01 << code;
  endfunction : step_size
endpackage : fan_regs_pkg
`default_nettype wire

/* File: include/ramp_if.sv */
/*
  Carrier between the register bank and the duty ramp engine.
  Assumes the engine is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface ramp_if;
  fan_regs_pkg::fan_mode_t mode;
  logic [7:0] cur_duty;
  logic [7:0] target_duty;
  logic [7:0] ramp_cfg;
  logic [15:0] tach_now;
  logic [15:0] tach_target;
  logic [7:0] next_duty;
  modport ctrl (output mode, cur_duty, target_duty, ramp_cfg, tach_now, tach_target,
    input next_duty);
  modport engine (input mode, cur_duty, target_duty, ramp_cfg, tach_now, tach_target,
    output next_duty);
endinterface : ramp_if
`default_nettype wire

/* File: hdl/update_tick_gen.sv */
/*
  Duty update tick generator. Assumes mode and rate inputs come from
  registers in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module update_tick_gen #(
  parameter int BASE_CYCLES = fan_regs_pkg::UPDATE_BASE_CYCLES,
  parameter int SLOW_CYCLES = fan_regs_pkg::TACH_SLOW_CYCLES,
  parameter int FAST_CYCLES = fan_regs_pkg::TACH_FAST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire fan_regs_pkg::fan_mode_t mode,
  input wire logic [2:0] rate_code,
  input wire logic tach_fast,
  output logic tick
);
  // the base period is shifted left by up to seven rate steps in 32 bits
  if (BASE_CYCLES < 1 || SLOW_CYCLES < 1 || FAST_CYCLES < 1 || BASE_CYCLES > 32'h01ffffff)
  begin : g_bad_period
    $error("update_tick_gen: period parameters out of range");
  end

  logic [31:0] count;
  wire [31:0] auto_period;
  wire [31:0] period;
  assign auto_period = 32'(BASE_CYCLES) << (fan_regs_pkg::RATE_FASTEST - rate_code);
  assign period = (mode == fan_regs_pkg::MODE_SW_RPM) ?
    (tach_fast ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES)) : auto_period;
  assign tick = (count >= period - 32'h1);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      count <= 32'h0;
    else
      count <= tick ? 32'h0 : count + 32'h1;
  end

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
    tick |=> !tick || (period == 32'h1)) else $error("tick repeated too soon");
endmodule : update_tick_gen
`default_nettype wire

/* File: hdl/duty_ramp_engine.sv */
/*
  Combinational duty step calculation. Assumes the caller applies the
  result only on update ticks and handles the passive cooling force.
*/
`timescale 1ns/10ps
`default_nettype none
module duty_ramp_engine (
  ramp_if.engine rif
);
  wire ramp_en;
  wire [7:0] step;
  wire [7:0] thresh;
  wire [7:0] duty_gap;
  wire [7:0] move;
  wire toward_up;
  wire [15:0] tach_gap;
  wire tach_settled;
  wire [7:0] rpm_room;
  wire [7:0] rpm_move;
  wire [7:0] auto_next;
  wire [7:0] rpm_next;

  assign ramp_en = rif.ramp_cfg[fan_regs_pkg::RAMP_EN_BIT];
  assign step = fan_regs_pkg::step_size(rif.ramp_cfg[fan_regs_pkg::STEP_LSB +: 2]);
  assign thresh = {6'h0, rif.ramp_cfg[fan_regs_pkg::THRESH_LSB +: 2]} + 8'h01;
  assign toward_up = rif.target_duty > rif.cur_duty;
  assign duty_gap = toward_up ? rif.target_duty - rif.cur_duty : rif.cur_duty - rif.target_duty;
  assign move = (duty_gap < step) ? duty_gap : step;

  assign auto_next = (duty_gap <= thresh) ? rif.cur_duty :
    !ramp_en ? rif.target_duty :
    toward_up ? rif.cur_duty + move : rif.cur_duty - move;

  assign tach_gap = fan_regs_pkg::abs_diff16(rif.tach_now, rif.tach_target);
  assign tach_settled = tach_gap <= fan_regs_pkg::TACH_WINDOW;
  // longer period than target means the fan is slow, so raise duty
  assign rpm_room = (rif.tach_now > rif.tach_target) ? 8'hff - rif.cur_duty : rif.cur_duty;
  assign rpm_move = (rpm_room < step) ? rpm_room : step;
  assign rpm_next = tach_settled ? rif.cur_duty :
    (rif.tach_now > rif.tach_target) ? rif.cur_duty + rpm_move : rif.cur_duty - rpm_move;

  assign rif.next_duty = (rif.mode == fan_regs_pkg::MODE_AUTO_TEMP) ? auto_next :
    (rif.mode == fan_regs_pkg::MODE_SW_RPM) ? rpm_next : rif.target_duty;
endmodule : duty_ramp_engine
`default_nettype wire

/* File: hdl/fan_ramp_regs.sv */
/*
  Fan duty ramp control and measurement register bank: temperature and
  tach data with coherent multi-byte reads, limit registers, passive
  cooling threshold and the duty ramp register. Assumes a byte-wide
  register port decoded from the serial management bus, one read or
  write strobe per transaction, and sensor/tach samples as one-cycle
  valid pulses in the sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module fan_ramp_regs #(
  parameter int BASE_CYCLES = fan_regs_pkg::UPDATE_BASE_CYCLES,
  parameter int SLOW_CYCLES = fan_regs_pkg::TACH_SLOW_CYCLES,
  parameter int FAST_CYCLES = fan_regs_pkg::TACH_FAST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [10:0] local_reading_bits,
  input wire logic local_valid,
  input wire logic [10:0] remote_reading_bits,
  input wire logic remote_valid,
  input wire logic [15:0] revolution_period_count,
  input wire logic tach_valid,
  input wire fan_regs_pkg::fan_mode_t mode,
  input wire logic tach_fast,
  input wire logic active_is_remote,
  input wire logic [7:0] target_duty,
  input wire logic [15:0] tach_target,
  output logic [7:0] duty_cycle_value,
  output logic passive_stop,
  output logic update_tick
);
  // newest samples, always refreshed
  logic [10:0] local_live;
  logic [10:0] remote_live;
  // visible copies, frozen by the fraction read
  logic [10:0] local_shown;
  logic [10:0] remote_shown;
  logic temp_frozen;
  logic [15:0] period_live;
  logic [7:0] period_high_hold;
  logic period_frozen;
  logic [7:0] local_upper_bound;
  logic [7:0] local_lower_bound;
  logic [7:0] local_thermal_threshold;
  logic [7:0] remote_upper_bound;
  logic [7:0] remote_lower_bound;
  logic [7:0] remote_thermal_threshold;
  logic [7:0] local_critical_threshold;
  logic [7:0] remote_critical_threshold;
  logic [7:0] passive_cooling_level;
  logic [7:0] duty_ramp_cfg;

  wire rd_fraction;
  wire rd_remote_high;
  wire rd_period_low;
  wire rd_period_high;
  wire [7:0] temp_fraction_bits;
  wire [10:0] active_reading;
  wire below_passive;
  wire auto_mode;
  logic [7:0] next_rdata;

  // tick periods must fit the counter after the widest rate shift
  if (BASE_CYCLES < 1 || BASE_CYCLES > 32'h01ffffff || SLOW_CYCLES < 1 || FAST_CYCLES < 1)
  begin : g_bad_period
    $error("fan_ramp_regs: tick period parameters out of range");
  end

  ramp_if rif ();

  assign rd_fraction = reg_rd && reg_addr == fan_regs_pkg::ADDR_TEMP_FRACTION;
  assign rd_remote_high = reg_rd && reg_addr == fan_regs_pkg::ADDR_REMOTE_HIGH;
  assign rd_period_low = reg_rd && reg_addr == fan_regs_pkg::ADDR_PERIOD_LOW;
  assign rd_period_high = reg_rd && reg_addr == fan_regs_pkg::ADDR_PERIOD_HIGH;
  assign auto_mode = mode == fan_regs_pkg::MODE_AUTO_TEMP;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      local_live <= {fan_regs_pkg::RST_TEMP_HIGH, 3'h0};
      remote_live <= {fan_regs_pkg::RST_TEMP_HIGH, 3'h0};
      period_live <= 16'h0;
    end
    else
    begin
      if (local_valid)
        local_live <= local_reading_bits;
      if (remote_valid)
        remote_live <= remote_reading_bits;
      if (tach_valid)
        period_live <= revolution_period_count;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      temp_frozen <= 1'b0;
    else if (rd_fraction)
      temp_frozen <= 1'b1;
    else if (rd_remote_high)
      temp_frozen <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      local_shown <= {fan_regs_pkg::RST_TEMP_HIGH, 3'h0};
      remote_shown <= {fan_regs_pkg::RST_TEMP_HIGH, 3'h0};
    end
    else if (!temp_frozen && !rd_fraction)
    begin
      local_shown <= local_valid ? local_reading_bits : local_live;
      remote_shown <= remote_valid ? remote_reading_bits : remote_live;
    end
  end

  // tach high held after low read
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      period_frozen <= 1'b0;
      period_high_hold <= 8'h00;
    end
    else if (rd_period_low)
    begin
      period_frozen <= 1'b1;
      period_high_hold <= period_live[15:8];
    end
    else if (rd_period_high)
      period_frozen <= 1'b0;
  end

  assign temp_fraction_bits = {local_shown[2:0], 2'b00, remote_shown[2:0]};

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      local_upper_bound <= fan_regs_pkg::RST_LOCAL_UPPER;
      local_lower_bound <= 8'h00;
      local_thermal_threshold <= fan_regs_pkg::RST_LOCAL_THERMAL;
      remote_upper_bound <= fan_regs_pkg::RST_REMOTE_UPPER;
      remote_lower_bound <= 8'h00;
      remote_thermal_threshold <= fan_regs_pkg::RST_REMOTE_THERMAL;
      local_critical_threshold <= fan_regs_pkg::RST_LOCAL_CRITICAL;
      remote_critical_threshold <= fan_regs_pkg::RST_REMOTE_CRITICAL;
      passive_cooling_level <= 8'h00;
      duty_ramp_cfg <= fan_regs_pkg::RST_DUTY_RAMP;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        fan_regs_pkg::ADDR_LOCAL_UPPER: local_upper_bound <= reg_wdata;
        fan_regs_pkg::ADDR_LOCAL_LOWER: local_lower_bound <= reg_wdata;
        fan_regs_pkg::ADDR_LOCAL_THERMAL: local_thermal_threshold <= reg_wdata;
        fan_regs_pkg::ADDR_REMOTE_UPPER: remote_upper_bound <= reg_wdata;
        fan_regs_pkg::ADDR_REMOTE_LOWER: remote_lower_bound <= reg_wdata;
        fan_regs_pkg::ADDR_REMOTE_THERMAL: remote_thermal_threshold <= reg_wdata;
        fan_regs_pkg::ADDR_LOCAL_CRITICAL: local_critical_threshold <= reg_wdata;
        fan_regs_pkg::ADDR_REMOTE_CRITICAL: remote_critical_threshold <= reg_wdata;
        fan_regs_pkg::ADDR_PASSIVE:
          passive_cooling_level <= reg_wdata & fan_regs_pkg::PASSIVE_MASK;
        fan_regs_pkg::ADDR_DUTY_RAMP: duty_ramp_cfg <= reg_wdata;
        // read-only and unmapped addresses ignore writes
        default: ;
      endcase
    end
  end

  // readback mux; unmapped addresses read zero
  // high byte alone is whole degrees
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      fan_regs_pkg::ADDR_TEMP_FRACTION: next_rdata = temp_fraction_bits;
      fan_regs_pkg::ADDR_PERIOD_LOW: next_rdata = period_live[7:0];
      fan_regs_pkg::ADDR_PERIOD_HIGH:
        next_rdata = period_frozen ? period_high_hold : period_live[15:8];
      fan_regs_pkg::ADDR_LOCAL_HIGH: next_rdata = local_shown[10:3];
      fan_regs_pkg::ADDR_REMOTE_HIGH: next_rdata = remote_shown[10:3];
      fan_regs_pkg::ADDR_LOCAL_UPPER: next_rdata = local_upper_bound;
      fan_regs_pkg::ADDR_LOCAL_LOWER: next_rdata = local_lower_bound;
      fan_regs_pkg::ADDR_LOCAL_THERMAL: next_rdata = local_thermal_threshold;
      fan_regs_pkg::ADDR_REMOTE_UPPER: next_rdata = remote_upper_bound;
      fan_regs_pkg::ADDR_REMOTE_LOWER: next_rdata = remote_lower_bound;
      fan_regs_pkg::ADDR_REMOTE_THERMAL: next_rdata = remote_thermal_threshold;
      fan_regs_pkg::ADDR_LOCAL_CRITICAL: next_rdata = local_critical_threshold;
      fan_regs_pkg::ADDR_PASSIVE: next_rdata = passive_cooling_level;
      fan_regs_pkg::ADDR_REMOTE_CRITICAL: next_rdata = remote_critical_threshold;
      fan_regs_pkg::ADDR_DUTY_RAMP: next_rdata = duty_ramp_cfg;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  assign active_reading = active_is_remote ? remote_live : local_live;
  assign below_passive = $signed(active_reading) <= $signed({passive_cooling_level, 3'h0});

  update_tick_gen #(
    .BASE_CYCLES(BASE_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES),
    .FAST_CYCLES(FAST_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .mode(mode),
    .rate_code(duty_ramp_cfg[fan_regs_pkg::RATE_LSB +: 3]),
    .tach_fast(tach_fast),
    .tick(update_tick)
  );

  assign rif.mode = mode;
  assign rif.cur_duty = duty_cycle_value;
  assign rif.target_duty = target_duty;
  assign rif.ramp_cfg = duty_ramp_cfg;
  assign rif.tach_now = period_live;
  assign rif.tach_target = tach_target;

  duty_ramp_engine u_engine (
    .rif(rif.engine)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      duty_cycle_value <= 8'h00;
      passive_stop <= 1'b0;
    end
    else
    begin
      passive_stop <= auto_mode && below_passive;
      if (auto_mode && below_passive)
        duty_cycle_value <= 8'h00;
      else if (mode == fan_regs_pkg::MODE_SW_DUTY)
        duty_cycle_value <= target_duty;
      else if (update_tick)
        duty_cycle_value <= rif.next_duty;
    end
  end

  a_passive_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    auto_mode && below_passive |=> duty_cycle_value == 8'h00)
    else $error("duty not zero below passive threshold");

  a_temp_freeze: assert property (@(posedge sys_clk) disable iff (!rstn)
    temp_frozen && !rd_remote_high |=> $stable(local_shown) && $stable(remote_shown))
    else $error("temperature data changed while frozen");

  a_freeze_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_fraction |=> temp_frozen) else $error("fraction read did not freeze");

  a_tach_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_period_low |=> period_frozen && period_high_hold == $past(period_live[15:8]))
    else $error("tach high byte torn");

  a_tach_give: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_period_high |=> !period_frozen && reg_rdata == ($past(period_frozen) ?
      $past(period_high_hold) : $past(period_live[15:8])))
    else $error("tach high byte wrong");

  a_fraction_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_fraction |=> reg_rdata[4:3] == 2'b00) else $error("fraction bits 4:3 not zero");

  a_passive_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
    passive_cooling_level[7:6] == 2'b00) else $error("passive threshold top bits set");

  a_tach_window: assert property (@(posedge sys_clk) disable iff (!rstn)
    mode == fan_regs_pkg::MODE_SW_RPM && update_tick
    && fan_regs_pkg::abs_diff16(period_live, tach_target) <= fan_regs_pkg::TACH_WINDOW
    |=> $stable(duty_cycle_value)) else $error("duty moved inside tach window");

  a_step_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    mode != fan_regs_pkg::MODE_SW_DUTY && !below_passive && update_tick
    && (duty_ramp_cfg[fan_regs_pkg::RAMP_EN_BIT] || mode == fan_regs_pkg::MODE_SW_RPM)
    |=> fan_regs_pkg::abs_diff16({8'h00, duty_cycle_value}, {8'h00, $past(duty_cycle_value)})
      <= {8'h00, fan_regs_pkg::step_size($past(duty_ramp_cfg[fan_regs_pkg::STEP_LSB +: 2]))})
    else $error("duty moved more than one step");

  a_deadband: assert property (@(posedge sys_clk) disable iff (!rstn)
    auto_mode && !below_passive && update_tick
    && fan_regs_pkg::abs_diff16({8'h00, duty_cycle_value}, {8'h00, target_duty})
      <= {14'h0, duty_ramp_cfg[fan_regs_pkg::THRESH_LSB +: 2]} + 16'h1
    |=> $stable(duty_cycle_value)) else $error("duty moved inside deadband");

  a_freeze_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_remote_high |=> !temp_frozen) else $error("remote high read did not thaw");

  a_live_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    local_valid && remote_valid |=> local_live == $past(local_reading_bits)
    && remote_live == $past(remote_reading_bits)) else $error("live sample dropped");

  a_shown_track: assert property (@(posedge sys_clk) disable iff (!rstn)
    !temp_frozen && !rd_fraction && local_valid |=> local_shown == $past(local_reading_bits))
    else $error("visible local reading stale");

  a_ramp_jump: assert property (@(posedge sys_clk) disable iff (!rstn)
    auto_mode && !below_passive && update_tick && !duty_ramp_cfg[fan_regs_pkg::RAMP_EN_BIT]
    && fan_regs_pkg::abs_diff16({8'h00, duty_cycle_value}, {8'h00, target_duty}) > 16'h0004
    |=> duty_cycle_value == $past(target_duty)) else $error("ramp off did not jump");

  a_rpm_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    mode == fan_regs_pkg::MODE_SW_RPM && update_tick && duty_cycle_value inside {[8'h08:8'hf7]}
    && fan_regs_pkg::abs_diff16(period_live, tach_target) > fan_regs_pkg::TACH_WINDOW
    |=> fan_regs_pkg::abs_diff16({8'h00, duty_cycle_value}, {8'h00, $past(duty_cycle_value)})
      == {8'h00, fan_regs_pkg::step_size($past(duty_ramp_cfg[fan_regs_pkg::STEP_LSB +: 2]))})
    else $error("rpm step size wrong");
endmodule : fan_ramp_regs
`default_nettype wire

/* File: bench/host_model.sv */
/*
  Host model driving the byte-wide register port, one strobe per transfer.
  Assumes read data is valid one cycle after the read strobe edge.
*/
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* File: bench/fan_ramp_regs_bench.sv */
/*
  Self-checking bench for fan_ramp_regs with a behavioural duty model.
  Assumes short tick periods: base 4, slow 8, fast 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module fan_ramp_regs_bench;
  localparam fan_regs_pkg::fan_mode_t SW = fan_regs_pkg::MODE_SW_DUTY;
  localparam fan_regs_pkg::fan_mode_t AUTO = fan_regs_pkg::MODE_AUTO_TEMP;
  localparam fan_regs_pkg::fan_mode_t RPM = fan_regs_pkg::MODE_SW_RPM;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, target_duty, duty_cycle_value, m_ramp, d0, d1, d2;
  logic reg_wr, reg_rd, local_valid, remote_valid, tach_valid, tach_fast, active_is_remote;
  logic passive_stop, update_tick, chk_on, m_tick;
  logic [10:0] local_reading_bits, remote_reading_bits;
  logic [15:0] revolution_period_count, tach_target;
  logic [31:0] r;
  logic [31:0] seed = 32'h421a;
  fan_regs_pkg::fan_mode_t mode;
  int errors, cmp_count, cycles, m_duty, m_tach, gap, ag, stp, tg;
  logic [7:0] rst_addr [16] = '{8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h14, 8'h15, 8'h16,
    8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h23, 8'h30};
  logic [7:0] rst_val [16] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h3c, 8'h00, 8'h46,
    8'h50, 8'h00, 8'h64, 8'h50, 8'h00, 8'h69, 8'h52, 8'h00};

  host_model host_model_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  fan_ramp_regs #(.BASE_CYCLES(4), .SLOW_CYCLES(8), .FAST_CYCLES(4)) fan_ramp_regs_i (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .local_reading_bits, .local_valid, .remote_reading_bits, .remote_valid,
    .revolution_period_count, .tach_valid, .mode, .tach_fast, .active_is_remote,
    .target_duty, .tach_target, .duty_cycle_value, .passive_stop, .update_tick);

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_model_i.rd(a, d);
    check(16'(d), 16'(e));
  endtask : rchk

  task automatic sample(input logic [10:0] l, input logic [10:0] rm, input logic [15:0] t);
    @(negedge sys_clk);
    {local_reading_bits, remote_reading_bits, revolution_period_count} = {l, rm, t};
    m_tach = t;
    {local_valid, remote_valid, tach_valid} = 3'h7;
    @(negedge sys_clk);
    {local_valid, remote_valid, tach_valid} = 3'h0;
    {local_reading_bits, remote_reading_bits, revolution_period_count} = ~{l, rm, t};
  endtask : sample

  task automatic setramp(input logic [7:0] v);
    host_model_i.wr(8'h23, v);
    // model takes the new setting once the write has landed
    m_ramp = v;
  endtask : setramp

  task automatic tick_gap(input int exp);
    int n;
    @(negedge sys_clk);
    for (n = 0; n < 999 && update_tick !== 1'b1; n++)
      @(negedge sys_clk);
    repeat (2)
    begin
      for (n = 1; n < 999; n++)
      begin
        @(negedge sys_clk);
        if (update_tick === 1'b1)
          break;
      end
    end
    check(16'(n), 16'(exp));
  endtask : tick_gap

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  // duty model: compare after each update, then predict the next edge
  always @(negedge sys_clk)
  begin
    if (chk_on && m_tick)
      check(16'(duty_cycle_value), 16'(m_duty));
    #4;
    m_tick = update_tick === 1'b1 || mode == SW;
    stp = 1 << m_ramp[6:5];
    gap = int'(target_duty) - m_duty;
    ag = gap < 0 ? -gap : gap;
    tg = m_tach - int'(tach_target);
    if (rstn !== 1'b1)
      m_duty = 0;
    else if (mode == SW)
      m_duty = target_duty;
    else if (update_tick === 1'b1 && mode == AUTO && ag > m_ramp[1:0] + 1)
      m_duty = !m_ramp[7] || ag <= stp ? target_duty : m_duty + (gap > 0 ? stp : -stp);
    else if (update_tick === 1'b1 && mode == RPM && tg > 10)
      m_duty = m_duty + stp > 255 ? 255 : m_duty + stp;
    else if (update_tick === 1'b1 && mode == RPM && tg < -10)
      m_duty = m_duty < stp ? 0 : m_duty - stp;
  end

  initial
  begin
    {local_valid, remote_valid, tach_valid, tach_fast, active_is_remote} = 5'h00;
    {local_reading_bits, remote_reading_bits, revolution_period_count} = 38'h0;
    {target_duty, tach_target} = 24'h0;
    mode = SW;
    m_ramp = 8'h52;
    chk_on = 1'b1;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    for (int i = 0; i < 16; i++)
      rchk(rst_addr[i], rst_val[i]);
    host_model_i.wr(8'h0a, 8'h11);
    host_model_i.wr(8'h30, 8'h22);
    rchk(8'h0a, 8'h80);
    rchk(8'h30, 8'h00);
    for (int i = 5; i < 15; i++)
    begin
      d0 = 8'(rnd());
      host_model_i.wr(rst_addr[i], d0);
      rchk(rst_addr[i], rst_addr[i] == 8'h1c ? d0 & 8'h3f : d0);
    end
    r = rnd();
    sample(r[10:0], r[26:16], r[31:16]);
    host_model_i.rd(8'h06, d0);
    sample(~r[10:0], ~r[26:16], r[15:0]);
    host_model_i.rd(8'h0a, d1);
    host_model_i.rd(8'h0b, d2);
    check({5'h00, d1, d0[7:5]}, {5'h00, r[10:0]});
    check({5'h00, d2, d0[2:0]}, {5'h00, r[26:16]});
    check(16'(d0[4:3]), 16'h0000);
    rchk(8'h0a, ~r[10:3]);
    rchk(8'h0b, ~r[26:19]);
    host_model_i.rd(8'h08, d0);
    sample(11'h190, 11'h190, 16'h1000);
    host_model_i.rd(8'h09, d1);
    check({d1, d0}, r[15:0]);
    rchk(8'h09, 8'h10);
    host_model_i.wr(8'h1c, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      mode = SW;
      target_duty = 8'h80;
      setramp({i < 4, 2'(i), 3'h7, 2'(i)});
      target_duty = 8'(rnd());
      mode = AUTO;
      repeat (1100) @(negedge sys_clk);
    end
    tick_gap(4);
    setramp(8'h90);
    tick_gap(32);
    setramp(8'h60);
    tach_fast = 1'b1;
    mode = RPM;
    tick_gap(4);
    tach_target = 16'h0ff6;
    repeat (40) @(negedge sys_clk);
    tach_target = 16'h0f00;
    repeat (200) @(negedge sys_clk);
    tach_fast = 1'b0;
    tick_gap(8);
    tach_target = 16'h2000;
    repeat (300) @(negedge sys_clk);
    chk_on = 1'b0;
    mode = SW;
    target_duty = 8'h40;
    host_model_i.wr(8'h1c, 8'h3f);
    active_is_remote = 1'b1;
    mode = AUTO;
    repeat (4) @(negedge sys_clk);
    check(16'(passive_stop), 16'h0001);
    check(16'(duty_cycle_value), 16'h0000);
    host_model_i.wr(8'h1c, 8'h10);
    repeat (4) @(negedge sys_clk);
    check(16'(passive_stop), 16'h0000);
    wrap_up();
  end
endmodule : fan_ramp_regs_bench
`default_nettype wire
